// >>> fsfu_consts.svh
// fault status flag constants: offsets, bit positions, reset values
`ifndef FSFU_CONSTS_SVH
`define FSFU_CONSTS_SVH

`define FSFU_FAULT_STATUS_OFS 12'hD28
`define FSFU_BUS_BYTE_OFS 12'hD29
`define FSFU_USAGE_HALF_OFS 12'hD2A
`define FSFU_INVALID_STATE_POS 17
`define FSFU_UNDEFINED_INSTR_POS 16
`define FSFU_ADDR_VALID_POS 15
`define FSFU_RSVD_HI_POS 14
`define FSFU_RSVD_LO_POS 13
`define FSFU_STATUS_RESET 32'h0000_0000
`define FSFU_FLAG_RESET 1'b0
`define FSFU_FLAG_COUNT 3

`endif

// >>> fsfu_pkg.sv
// fault status flag types
package fsfu_pkg;
  typedef logic [31:0] fsfu_word_type;
  typedef logic [3:0] fsfu_lanes_type;
  typedef logic [11:0] fsfu_offset_type;
endpackage : fsfu_pkg

// >>> fsfu_w1c_flag.sv
// one sticky write-one-to-clear fault flag
`timescale 1ns/100ps
`default_nettype none
`include "fsfu_consts.svh"

module fsfu_w1c_flag (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic set_evt,
  input wire logic clear_w1c,
  input wire logic drop_evt,
  output logic flag_q
);
  logic flag_d;

  // set wins over any clear in the same cycle
  always_comb begin
    flag_d = set_evt | (flag_q & ~clear_w1c & ~drop_evt);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= `FSFU_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule : fsfu_w1c_flag

`default_nettype wire

// >>> fsfu_capture_reg.sv
// load-enabled capture register for fault addresses and return counters
`timescale 1ns/100ps
`default_nettype none

module fsfu_capture_reg #(
  parameter int WIDTH = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout_q
);
  logic [WIDTH-1:0] dout_d;

  always_comb begin
    dout_d = load ? din : dout_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
    end else begin
      dout_q <= dout_d;
    end
  end
endmodule : fsfu_capture_reg

`default_nettype wire

// >>> fsfu_fault_status.sv
// fault status flags: invalid state, undefined instruction, bus address valid
// Summary of operation
// - illegal execution-state-register use sets the invalid-state flag, bit 17
// - invalid-state fault saves the offending instruction's address as return counter
// - undefined instruction touching the execution state register leaves invalid-state clear
// - undefined instruction attempt sets the undefined-instruction flag, bit 16
// - undefined-instruction fault saves the undefined instruction's address as return counter
// - anything the decoder cannot decode counts as undefined
// - bus fault with known address sets address-valid flag, bit 15
// - a later different fault, such as memory management, may clear address-valid
// - a write clears a flag only where it has a one; zero leaves it unchanged
// - bits 14:13 reserved, read zero, writes ignored
// - whole register readable and clearable by word access at offset 0xD28
// - usage halfword 31:16 and bus byte 15:8 accessible independently
`timescale 1ns/100ps
`default_nettype none
`include "fsfu_consts.svh"

module fsfu_fault_status (
  input wire logic mclk,
  input wire logic rst_n,
  // system space access, word aligned with byte lanes
  input wire logic sys_sel,
  input wire logic sys_write,
  input wire logic [11:0] sys_addr,
  input wire logic [3:0] sys_byte_en,
  input wire logic [31:0] sys_wdata,
  output logic [31:0] sys_rdata,
  output logic sys_ack,
  // decoder and fault capture path
  input wire logic dec_undefined,
  input wire logic dec_illegal_state,
  input wire logic [31:0] instr_pc,
  input wire logic bus_fault,
  input wire logic bus_fault_addr_known,
  input wire logic [31:0] bus_fault_addr,
  input wire logic mem_fault,
  // flag and capture outputs
  output logic invalid_state_flag,
  output logic undefined_instr_flag,
  output logic bus_fault_addr_valid,
  output logic [31:0] stacked_return_pc,
  output logic [31:0] bus_fault_address_reg
);
  localparam int NFLAG = `FSFU_FLAG_COUNT;
  localparam int FLAG_POS [NFLAG] = '{
    `FSFU_INVALID_STATE_POS, `FSFU_UNDEFINED_INSTR_POS, `FSFU_ADDR_VALID_POS};

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic fsfu_hit(input fsfu_pkg::fsfu_offset_type addr);
    logic [11:0] base;
    base = `FSFU_FAULT_STATUS_OFS;
    if (addr[11:2] == base[11:2]) begin
      fsfu_hit = 1'b1;
    end else begin
      fsfu_hit = 1'b0;
    end
  endfunction : fsfu_hit

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = sys_sel & sys_write & fsfu_hit(sys_addr);
  assign rd_hit = sys_sel & ~sys_write & fsfu_hit(sys_addr);

  // ---------------------------------------------------------------
  // event qualification
  // ---------------------------------------------------------------
  logic undefined_instr_flag_evt;
  logic inv_evt;
  logic bus_fault_addr_valid_evt;
  logic usage_evt;
  // the decoder's undefined signal covers every undecodable pattern
  assign undefined_instr_flag_evt = dec_undefined;
  // undefined wins: no invalid-state cause for an undefined opcode
  assign inv_evt = dec_illegal_state & ~dec_undefined;
  assign bus_fault_addr_valid_evt = bus_fault & bus_fault_addr_known;
  assign usage_evt = undefined_instr_flag_evt | inv_evt;

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  logic [NFLAG-1:0] set_vec;
  logic [NFLAG-1:0] clr_vec;
  logic [NFLAG-1:0] drop_vec;
  logic [NFLAG-1:0] flag_vec;

  assign set_vec = {bus_fault_addr_valid_evt, undefined_instr_flag_evt, inv_evt};
  // only the address-valid flag is dropped by an unrelated later fault
  assign drop_vec = {mem_fault, 1'b0, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      // clear needs the owning byte lane enabled and a one in the bit
      assign clr_vec[gi] = wr_hit & sys_byte_en[FLAG_POS[gi] / 8]
                           & sys_wdata[FLAG_POS[gi]];
      fsfu_w1c_flag u_flag (
        .mclk(mclk),
        .rst_n(rst_n),
        .set_evt(set_vec[gi]),
        .clear_w1c(clr_vec[gi]),
        .drop_evt(drop_vec[gi]),
        .flag_q(flag_vec[gi])
      );
    end
  endgenerate

  assign invalid_state_flag = flag_vec[0];
  assign undefined_instr_flag = flag_vec[1];
  assign bus_fault_addr_valid = flag_vec[2];

  // ---------------------------------------------------------------
  // captured return counter and fault address
  // ---------------------------------------------------------------
  // the faulting instruction itself is saved, not the next one
  fsfu_capture_reg #(.WIDTH(32)) u_ret_pc (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(usage_evt),
    .din(instr_pc),
    .dout_q(stacked_return_pc)
  );

  fsfu_capture_reg #(.WIDTH(32)) u_fault_addr (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(bus_fault_addr_valid_evt),
    .din(bus_fault_addr),
    .dout_q(bus_fault_address_reg)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  fsfu_pkg::fsfu_word_type status_word;
  fsfu_pkg::fsfu_word_type lane_mask;
  fsfu_pkg::fsfu_word_type rdata_d;
  logic ack_d;

  always_comb begin
    status_word = `FSFU_STATUS_RESET;
    for (int i = 0; i < NFLAG; i++) begin
      status_word[FLAG_POS[i]] = flag_vec[i];
    end
    // reserved bits never carry state
    status_word[`FSFU_RSVD_HI_POS:`FSFU_RSVD_LO_POS] = 2'b00;
    for (int i = 0; i < 4; i++) begin
      lane_mask[i*8 +: 8] = {8{sys_byte_en[i]}};
    end
    // unmapped reads answer zero so software never sees stale data
    rdata_d = rd_hit ? (status_word & lane_mask) : 32'h0000_0000;
    ack_d = sys_sel;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rdata <= 32'h0000_0000;
      sys_ack <= 1'b0;
    end else begin
      sys_rdata <= rdata_d;
      sys_ack <= ack_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence full_read_s;
    rd_hit && sys_byte_en == 4'hF;
  endsequence

  sequence read_answer_s;
    sys_ack ##0 sys_rdata[17:15] == {$past(flag_vec[0]), $past(flag_vec[1]), $past(flag_vec[2])};
  endsequence

  logic wr_clr_undefined_instr_flag;
  assign wr_clr_undefined_instr_flag = wr_hit && sys_byte_en[2] && sys_wdata[16];

  invalid_set_a: assert property (
    dec_illegal_state && !dec_undefined |=> invalid_state_flag)
    else $error("invalid-state flag not set");

  ret_pc_a: assert property (
    dec_illegal_state || dec_undefined |=> stacked_return_pc == $past(instr_pc))
    else $error("return counter not captured");

  undefined_instr_flag_masks_a: assert property (
    !invalid_state_flag && dec_undefined && dec_illegal_state |=> !invalid_state_flag)
    else $error("invalid-state set by undefined instruction");

  undefined_instr_flag_set_a: assert property (
    dec_undefined |=> undefined_instr_flag ##0 stacked_return_pc == $past(instr_pc))
    else $error("undefined flag or return counter wrong");

  addr_valid_a: assert property (
    bus_fault && bus_fault_addr_known
    |=> bus_fault_addr_valid && bus_fault_address_reg == $past(bus_fault_addr))
    else $error("address-valid or fault address wrong");

  valid_drop_a: assert property (
    mem_fault && !(bus_fault && bus_fault_addr_known) |=> !bus_fault_addr_valid)
    else $error("address-valid survived later fault");

  one_clears_a: assert property (
    wr_clr_undefined_instr_flag && !dec_undefined |=> !undefined_instr_flag)
    else $error("write one did not clear");

  zero_keeps_a: assert property (
    invalid_state_flag && !(wr_hit && sys_byte_en[2] && sys_wdata[17])
    |=> invalid_state_flag)
    else $error("flag lost without write one");

  rsvd_zero_a: assert property (
    sys_ack |-> sys_rdata[14:13] == 2'b00)
    else $error("reserved bits not zero");

  word_read_a: assert property (
    full_read_s |=> read_answer_s)
    else $error("word read does not show flags");

  lane_gate_a: assert property (
    undefined_instr_flag && wr_hit && !sys_byte_en[2] |=> undefined_instr_flag)
    else $error("disabled lane cleared a flag");

  sticky_a: assert property (
    bus_fault_addr_valid && !mem_fault && !wr_hit [*3] |=> bus_fault_addr_valid)
    else $error("address-valid not sticky");

  // ---------------------------------------------------------------
  // access answer and flag hold checks
  // ---------------------------------------------------------------
  ack_follows_a: assert property (
    sys_sel |=> sys_ack)
    else $error("access not acknowledged");

  ack_pulse_a: assert property (
    !sys_sel |=> !sys_ack)
    else $error("acknowledge without access");

  miss_zero_a: assert property (
    sys_sel && !rd_hit |=> sys_rdata == 32'h0000_0000)
    else $error("write or unmapped access returned data");

  bus_lane_a: assert property (
    rd_hit && !sys_byte_en[1] |=> sys_rdata[15:8] == 8'h00)
    else $error("disabled bus lane returned data");

  usage_lane_a: assert property (
    rd_hit && !sys_byte_en[2] |=> sys_rdata[23:16] == 8'h00)
    else $error("disabled usage lane returned data");

  other_bits_a: assert property (
    sys_ack |-> sys_rdata[31:18] == 14'h0000 && sys_rdata[12:0] == 13'h0000)
    else $error("unowned bits not zero");

  inv_clears_a: assert property (
    wr_hit && sys_byte_en[2] && sys_wdata[17] && !inv_evt |=> !invalid_state_flag)
    else $error("write one left invalid-state set");

  valid_clears_a: assert property (
    wr_hit && sys_byte_en[1] && sys_wdata[15] && !bus_fault_addr_valid_evt |=> !bus_fault_addr_valid)
    else $error("write one left address-valid set");

  set_wins_a: assert property (
    dec_undefined && wr_clr_undefined_instr_flag |=> undefined_instr_flag)
    else $error("clear beat a same-cycle undefined event");

  undefined_instr_flag_keeps_a: assert property (
    undefined_instr_flag && !wr_clr_undefined_instr_flag |=> undefined_instr_flag)
    else $error("undefined flag lost without write one");

  inv_quiet_a: assert property (
    !invalid_state_flag && !(dec_illegal_state && !dec_undefined) |=> !invalid_state_flag)
    else $error("invalid-state set without cause");

  undefined_instr_flag_quiet_a: assert property (
    !undefined_instr_flag && !dec_undefined |=> !undefined_instr_flag)
    else $error("undefined flag set without cause");

  valid_quiet_a: assert property (
    !bus_fault_addr_valid && !(bus_fault && bus_fault_addr_known) |=> !bus_fault_addr_valid)
    else $error("address-valid set without known address");

  pc_hold_a: assert property (
    !dec_undefined && !dec_illegal_state |=> $stable(stacked_return_pc))
    else $error("return counter changed without fault");

  addr_hold_a: assert property (
    !(bus_fault && bus_fault_addr_known) |=> $stable(bus_fault_address_reg))
    else $error("fault address changed without known bus fault");

endmodule : fsfu_fault_status

`default_nettype wire

// >>> test_fault_status_flags_usage_bus.sv
// testbench for the fault status flags block, driven through its system space port
`timescale 1ns/100ps
`default_nettype none
`include "fsfu_consts.svh"

module test_fault_status_flags_usage_bus;
  localparam logic [31:0] one = 32'h0000_0001;
  localparam logic [31:0] f_inv = one << `FSFU_INVALID_STATE_POS;
  localparam logic [31:0] f_und = one << `FSFU_UNDEFINED_INSTR_POS;
  localparam logic [31:0] f_bav = one << `FSFU_ADDR_VALID_POS;
  localparam logic [31:0] f_rsv = (one << `FSFU_RSVD_HI_POS) | (one << `FSFU_RSVD_LO_POS);
  localparam logic [11:0] a_wrd = `FSFU_FAULT_STATUS_OFS;
  localparam logic [11:0] a_bus = `FSFU_BUS_BYTE_OFS;
  localparam logic [11:0] a_use = `FSFU_USAGE_HALF_OFS;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sys_sel = 1'b0;
  logic sys_write = 1'b0;
  logic [11:0] sys_addr = 12'h000;
  logic [3:0] sys_byte_en = 4'h0;
  logic [31:0] sys_wdata = 32'h0000_0000;
  logic [31:0] sys_rdata;
  logic sys_ack;
  logic dec_undefined = 1'b0;
  logic dec_illegal_state = 1'b0;
  logic [31:0] instr_pc = 32'h0000_0000;
  logic bus_fault = 1'b0;
  logic bus_fault_addr_known = 1'b0;
  logic [31:0] bus_fault_addr = 32'h0000_0000;
  logic mem_fault = 1'b0;
  logic invalid_state_flag;
  logic undefined_instr_flag;
  logic bus_fault_addr_valid;
  logic [31:0] stacked_return_pc;
  logic [31:0] bus_fault_address_reg;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] flag_bits;
  assign flag_bits = {29'h0, invalid_state_flag, undefined_instr_flag, bus_fault_addr_valid};

  always #10 mclk = ~mclk;

  fsfu_fault_status u_dut (
    .mclk(mclk), .rst_n(rst_n), .sys_sel(sys_sel), .sys_write(sys_write),
    .sys_addr(sys_addr), .sys_byte_en(sys_byte_en), .sys_wdata(sys_wdata),
    .sys_rdata(sys_rdata), .sys_ack(sys_ack), .dec_undefined(dec_undefined),
    .dec_illegal_state(dec_illegal_state), .instr_pc(instr_pc), .bus_fault(bus_fault),
    .bus_fault_addr_known(bus_fault_addr_known), .bus_fault_addr(bus_fault_addr),
    .mem_fault(mem_fault), .invalid_state_flag(invalid_state_flag),
    .undefined_instr_flag(undefined_instr_flag), .bus_fault_addr_valid(bus_fault_addr_valid),
    .stacked_return_pc(stacked_return_pc), .bus_fault_address_reg(bus_fault_address_reg)
  );

  // ----------------------------------------
  // closing report
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ----------------------------------------
  // access and event drivers
  // ----------------------------------------
  // sel is one request per sampled edge, so it drops right after the taking edge
  task automatic acc(input logic wr, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd, input logic [31:0] exp);
    int n;
    @(posedge mclk);
    #1;
    sys_sel = 1'b1;
    sys_write = wr;
    sys_addr = a;
    sys_byte_en = be;
    sys_wdata = wd;
    @(posedge mclk);
    #1;
    sys_sel = 1'b0;
    // the answer stands only until the next edge, so look before waiting
    for (n = 0; n < 4; n++) begin
      if (sys_ack === 1'b1) break;
      @(posedge mclk);
      #1;
    end
    if (n == 4) begin
      miscompares++;
      test_done();
    end
    chk(sys_rdata, exp);
  endtask : acc

  task automatic evt(input logic und, input logic ill, input logic bf, input logic kn,
                     input logic mf, input logic [31:0] pc, input logic [31:0] fa);
    @(posedge mclk);
    #1;
    dec_undefined = und;
    dec_illegal_state = ill;
    bus_fault = bf;
    bus_fault_addr_known = kn;
    mem_fault = mf;
    instr_pc = pc;
    bus_fault_addr = fa;
    @(posedge mclk);
    #1;
    {dec_undefined, dec_illegal_state, bus_fault, bus_fault_addr_known, mem_fault} = 5'h00;
  endtask : evt

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, `FSFU_STATUS_RESET);
    evt(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_1234, 32'h0000_0000);
    chk(stacked_return_pc, 32'h0000_1234);
    chk({31'h0, undefined_instr_flag}, one);
    evt(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_2000, 32'h0000_0000);
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, f_und);
    acc(1'b1, a_wrd, 4'hF, 32'h0000_0000, 32'h0000_0000);
    // lane 2 left out: the ones must not reach bit 16
    acc(1'b1, a_wrd, 4'hB, 32'hFFFF_7FFF, 32'h0000_0000);
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, f_und);
    acc(1'b1, a_use, 4'hC, f_und, 32'h0000_0000);
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, 32'h0000_0000);
    evt(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_3000, 32'h0000_0000);
    chk(stacked_return_pc, 32'h0000_3000);
    chk({31'h0, invalid_state_flag}, one);
    acc(1'b0, a_use, 4'hC, 32'h0000_0000, f_inv);
    acc(1'b1, a_use, 4'hC, f_inv, 32'h0000_0000);
    evt(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_4000, 32'h0000_0000);
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, f_und);
    acc(1'b1, a_wrd, 4'hF, f_und, 32'h0000_0000);
    evt(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_5000);
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, 32'h0000_0000);
    evt(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0000, 32'h2000_0040);
    chk(bus_fault_address_reg, 32'h2000_0040);
    acc(1'b1, a_bus, 4'h2, f_rsv, 32'h0000_0000);
    acc(1'b0, a_bus, 4'h2, 32'h0000_0000, f_bav);
    evt(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0000, 32'h0000_0000);
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, 32'h0000_0000);
    evt(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0000, 32'h2000_0080);
    acc(1'b1, a_bus, 4'h2, f_bav, 32'h0000_0000);
    chk({31'h0, bus_fault_addr_valid}, 32'h0000_0000);
    acc(1'b0, 12'hD2C, 4'hF, 32'h0000_0000, 32'h0000_0000);
    evt(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_6000, 32'h2000_00C0);
    // reset in mid-run must drop every flag at once
    chk(flag_bits, 32'h0000_0003);
    rst_n = 1'b0;
    #1;
    chk(flag_bits, 32'h0000_0000);
    chk(stacked_return_pc | bus_fault_address_reg, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    acc(1'b0, a_wrd, 4'hF, 32'h0000_0000, `FSFU_STATUS_RESET);
    test_done();
  end
endmodule : test_fault_status_flags_usage_bus
`default_nettype wire
